// file: pkg/scl_pkg.sv
// package: strap config latch constants, register map and types
package scl_pkg;
  // axi4-lite register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ADV = 8'h04;
  localparam logic [7:0] ADDR_STRAP = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PIN_OUT = 8'h10;
  // control register bit positions
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_ISOLATE_BIT = 10;
  localparam int CTRL_AUTONEG_BIT = 12;
  localparam int CTRL_SPEED_BIT = 13;
  // advertisement register fields
  localparam int ADV_100_FD_BIT = 8;
  localparam int ADV_100_HD_BIT = 7;
  localparam int ADV_10_FD_BIT = 6;
  localparam int ADV_10_HD_BIT = 5;
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;
  // management address
  localparam logic [1:0] MGMT_ADDR_HI = 2'h0;
  localparam logic [4:0] MGMT_ADDR_DEFAULT = 5'h01;
  localparam logic [4:0] MGMT_ADDR_BCAST = 5'h00;
  // interface mode codes
  localparam logic [2:0] MODE_CODE_MII = 3'h0;
  localparam logic [2:0] MODE_CODE_B2B = 3'h6;
  // strap vector bit positions
  localparam int STRAP_W = 12;
  localparam int SP_ADDR0 = 0;
  localparam int SP_MODE0 = 3;
  localparam int SP_ISO = 6;
  localparam int SP_SPEED = 7;
  localparam int SP_DUPLEX = 8;
  localparam int SP_ANEG = 9;
  localparam int SP_BCAST_OFF = 10;
  localparam int SP_TEST_N = 11;
  // strap defaults (internal pull levels)
  localparam logic [11:0] STRAP_DEFAULT = 12'h B81;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // synchroniser depth before capture
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {SCL_MODE_MII, SCL_MODE_B2B, SCL_MODE_RSVD} scl_mode_t;

  typedef struct packed {
    logic [4:0] mgmt_addr;
    logic bcast_en;
    scl_mode_t mode;
    logic test_mode_en;
  } scl_cfg_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } scl_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } scl_axi_rsp_t;
endpackage

// file: rtl/scl_sync.sv
// two-flop synchroniser for the strap pin vector
`timescale 1ns/10ps
`default_nettype none
module scl_sync (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [scl_pkg::STRAP_W-1:0] d,
  output logic [scl_pkg::STRAP_W-1:0] q
);
  logic [scl_pkg::STRAP_W-1:0] meta_ff;
  logic [scl_pkg::STRAP_W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= scl_pkg::STRAP_DEFAULT;
      sync_ff <= scl_pkg::STRAP_DEFAULT;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// file: rtl/scl_axil.sv
// axi4-lite slave front end: handshakes, decode strobes
`timescale 1ns/10ps
`default_nettype none
module scl_axil (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire scl_pkg::scl_axi_req_t req,
  output scl_pkg::scl_axi_rsp_t rsp,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_rdy_ff;
  logic w_rdy_ff;
  logic ar_rdy_ff;

  assign aw_take = req.awvalid && aw_rdy_ff;
  assign w_take = req.wvalid && w_rdy_ff;
  assign ar_take = req.arvalid && ar_rdy_ff;

  assign wr_en = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;
  assign rd_en = ar_take;
  assign rd_addr = req.araddr;

  // address and data taken in either order, held until the write retires
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= req.awaddr;
      end
      if (w_take) begin
        w_got_ff <= 1'b1;
        wdata_ff <= req.wdata;
        wstrb_ff <= req.wstrb;
      end
      if (wr_en) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= scl_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_err ? scl_pkg::RESP_SLVERR : scl_pkg::RESP_OKAY;
    end else if (req.bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= scl_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_err ? scl_pkg::RESP_SLVERR : scl_pkg::RESP_OKAY;
    end else if (req.rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // readies from flops, no comb path valid to ready; costs one cycle per channel
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_rdy_ff <= 1'b0;
      w_rdy_ff <= 1'b0;
      ar_rdy_ff <= 1'b0;
    end else begin
      aw_rdy_ff <= req.awvalid && !aw_rdy_ff && !aw_got_ff && !bvalid_ff;
      w_rdy_ff <= req.wvalid && !w_rdy_ff && !w_got_ff && !bvalid_ff;
      ar_rdy_ff <= req.arvalid && !ar_rdy_ff && !rvalid_ff;
    end
  end

  always_comb begin
    rsp.awready = aw_rdy_ff;
    rsp.wready = w_rdy_ff;
    rsp.bvalid = bvalid_ff;
    rsp.bresp = bresp_ff;
    rsp.arready = ar_rdy_ff;
    rsp.rvalid = rvalid_ff;
    rsp.rdata = rdata_ff;
    rsp.rresp = rresp_ff;
  end
endmodule
`default_nettype wire

// file: rtl/scl_top.sv
// strap config latch: samples straps at reset release, seeds control registers
// Behaviour
// - the three low address straps are captured at reset release, giving 0 to 7.
// - with only internal pulls the adopted management address is 00001.
// - address bits 4 and 3 are always zero.
// - broadcast-disable low makes address 0 a broadcast address, high makes it unique.
// - the mode strap is captured; 000 is normal, 110 is back-to-back, others reserved.
// - the isolate strap seeds control bit 10, high meaning isolate.
// - the speed strap seeds control bit 13, high meaning 100 Mbps.
// - the speed strap also sets the speed capability bits of the advertisement register.
// - the duplex strap seeds control bit 8, high meaning half duplex.
// - the autoneg strap seeds control bit 12, high meaning enabled.
// - the connectivity test strap is captured, low enabling the test mode.
// - shared pins are inputs during reset and driven outputs once reset completes; the code drives them one cycle after capture, the fourth edge after release.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module scl_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire scl_pkg::scl_axi_req_t axi_req,
  output scl_pkg::scl_axi_rsp_t axi_rsp,
  input wire logic [2:0] mgmt_addr_strap_bit_i,
  input wire logic [2:0] mode_strap_i,
  input wire logic isolate_strap_i,
  input wire logic speed_strap_i,
  input wire logic duplex_strap_i,
  input wire logic autoneg_enable_strap,
  input wire logic broadcast_addr_disable_strap,
  input wire logic conn_test_strap_n_i,
  input wire logic [scl_pkg::STRAP_W-1:0] pin_func_out,
  output logic [scl_pkg::STRAP_W-1:0] pin_o,
  output logic [scl_pkg::STRAP_W-1:0] pin_oe,
  output logic cfg_valid,
  output scl_pkg::scl_cfg_t cfg,
  output logic [15:0] ctrl_reg,
  output logic [15:0] adv_reg
);
  logic [scl_pkg::STRAP_W-1:0] strap_raw;
  logic [scl_pkg::STRAP_W-1:0] strap_sync;
  logic [scl_pkg::STRAP_W-1:0] strap_ff;
  logic [scl_pkg::STRAP_W-1:0] pin_o_ff;
  logic [scl_pkg::STRAP_W-1:0] pin_oe_ff;
  logic [1:0] settle_ff;
  logic captured_ff;
  logic capture;
  scl_pkg::scl_cfg_t cfg_ff;
  scl_pkg::scl_cfg_t nxt_cfg;
  logic [15:0] ctrl_ff;
  logic [15:0] adv_ff;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_err;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = old;
    if (s[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (s[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  // 100 Mbps capability follows the speed strap, 10 Mbps bits always set
  function automatic logic [15:0] adv_seed(input logic spd);
    adv_seed = scl_pkg::ADV_SELECTOR;
    adv_seed[scl_pkg::ADV_10_HD_BIT] = 1'b1;
    adv_seed[scl_pkg::ADV_10_FD_BIT] = 1'b1;
    adv_seed[scl_pkg::ADV_100_HD_BIT] = spd;
    adv_seed[scl_pkg::ADV_100_FD_BIT] = spd;
  endfunction

  assign strap_raw = {conn_test_strap_n_i, broadcast_addr_disable_strap, autoneg_enable_strap,
                      duplex_strap_i, speed_strap_i, isolate_strap_i, mode_strap_i, mgmt_addr_strap_bit_i};

  scl_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d(strap_raw),
    .q(strap_sync)
  );

  // wait for synchroniser to fill after release, then capture once
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settle_ff <= 2'h0;
    end else if (settle_ff != 2'(scl_pkg::SYNC_STAGES)) begin
      settle_ff <= settle_ff + 2'h1;
    end
  end

  assign capture = (settle_ff == 2'(scl_pkg::SYNC_STAGES)) && !captured_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      captured_ff <= 1'b0;
    end else if (capture) begin
      captured_ff <= 1'b1;
    end
  end

  // snapshot held until the next reset, pins never resampled
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_ff <= scl_pkg::STRAP_DEFAULT;
    end else if (capture) begin
      strap_ff <= strap_sync;
    end
  end

  always_comb begin
    nxt_cfg.mgmt_addr = {scl_pkg::MGMT_ADDR_HI, strap_sync[scl_pkg::SP_ADDR0 +: 3]};
    nxt_cfg.bcast_en = !strap_sync[scl_pkg::SP_BCAST_OFF];
    unique case (strap_sync[scl_pkg::SP_MODE0 +: 3])
      scl_pkg::MODE_CODE_MII: nxt_cfg.mode = scl_pkg::SCL_MODE_MII;
      scl_pkg::MODE_CODE_B2B: nxt_cfg.mode = scl_pkg::SCL_MODE_B2B;
      default: nxt_cfg.mode = scl_pkg::SCL_MODE_RSVD;
    endcase
    nxt_cfg.test_mode_en = !strap_sync[scl_pkg::SP_TEST_N];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_ff <= '{mgmt_addr: scl_pkg::MGMT_ADDR_DEFAULT, bcast_en: 1'b1,
                  mode: scl_pkg::SCL_MODE_MII, test_mode_en: 1'b0};
    end else if (capture) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // seeded bits, software may overwrite afterwards
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= 16'h3100;
    end else if (capture) begin
      ctrl_ff <= 16'h0000;
      ctrl_ff[scl_pkg::CTRL_ISOLATE_BIT] <= strap_sync[scl_pkg::SP_ISO];
      ctrl_ff[scl_pkg::CTRL_SPEED_BIT] <= strap_sync[scl_pkg::SP_SPEED];
      ctrl_ff[scl_pkg::CTRL_DUPLEX_BIT] <= strap_sync[scl_pkg::SP_DUPLEX];
      ctrl_ff[scl_pkg::CTRL_AUTONEG_BIT] <= strap_sync[scl_pkg::SP_ANEG];
    end else if (wr_en && wr_addr == scl_pkg::ADDR_CTRL) begin
      ctrl_ff <= merge16(ctrl_ff, wr_data, wr_strb);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adv_ff <= adv_seed(1'b1);
    end else if (capture) begin
      adv_ff <= adv_seed(strap_sync[scl_pkg::SP_SPEED]);
    end else if (wr_en && wr_addr == scl_pkg::ADDR_ADV) begin
      adv_ff <= merge16(adv_ff, wr_data, wr_strb);
    end
  end

  // pins stay inputs with pulls until capture is done, then drive
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_oe_ff <= 12'h000;
      pin_o_ff <= 12'h000;
    end else begin
      pin_oe_ff <= captured_ff ? 12'hFFF : 12'h000;
      pin_o_ff <= captured_ff ? pin_func_out : 12'h000;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (rd_addr)
      scl_pkg::ADDR_CTRL: rd_data = {16'h0000, ctrl_ff};
      scl_pkg::ADDR_ADV: rd_data = {16'h0000, adv_ff};
      scl_pkg::ADDR_STRAP: rd_data = {20'h0_0000, strap_ff};
      scl_pkg::ADDR_STATUS: rd_data = {22'h00_0000, captured_ff, cfg_ff};
      scl_pkg::ADDR_PIN_OUT: rd_data = {20'h0_0000, pin_oe_ff};
      default: rd_err = 1'b1;
    endcase
  end

  // only control and advertisement are writable
  assign wr_err = !(wr_addr == scl_pkg::ADDR_CTRL || wr_addr == scl_pkg::ADDR_ADV);

  scl_axil u_axil (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .req(axi_req),
    .rsp(axi_rsp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_en(),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err),
    .wr_err(wr_err)
  );

  assign pin_o = pin_o_ff;
  assign pin_oe = pin_oe_ff;
  assign cfg_valid = captured_ff;
  assign cfg = cfg_ff;
  assign ctrl_reg = ctrl_ff;
  assign adv_reg = adv_ff;
endmodule
`default_nettype wire

// file: verification/scl_board.sv
// board strap resistors on the shared configuration pins
`timescale 1ns/10ps
`default_nettype none
module scl_board (
  input wire logic [scl_pkg::STRAP_W-1:0] pull,
  input wire logic [scl_pkg::STRAP_W-1:0] pin_o,
  input wire logic [scl_pkg::STRAP_W-1:0] pin_oe,
  output logic [scl_pkg::STRAP_W-1:0] pin
);
  // resistor sets the level only while the device leaves the pin alone
  always_comb begin
    for (int i = 0; i < scl_pkg::STRAP_W; i++) pin[i] = pin_oe[i] ? pin_o[i] : pull[i];
  end
endmodule
`default_nettype wire

// file: verification/scl_top_assertions.sv
// checker for the strap config latch ports
`timescale 1ns/10ps
`default_nettype none
module scl_top_assertions (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [2:0] mgmt_addr_strap_bit_i,
  input wire logic [2:0] mode_strap_i,
  input wire logic isolate_strap_i,
  input wire logic speed_strap_i,
  input wire logic duplex_strap_i,
  input wire logic autoneg_enable_strap,
  input wire logic broadcast_addr_disable_strap,
  input wire logic conn_test_strap_n_i,
  input wire logic [scl_pkg::STRAP_W-1:0] pin_oe,
  input wire logic cfg_valid,
  input wire scl_pkg::scl_cfg_t cfg,
  input wire logic [15:0] ctrl_reg,
  input wire logic [15:0] adv_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  capture_time_a: assert property ($rose(resetn) |-> !cfg_valid [*3] ##1 cfg_valid)
    else $error("capture not on third edge after release");
  pins_released_a: assert property (!cfg_valid |-> pin_oe == 12'h000)
    else $error("pins driven before capture");
  pins_driven_a: assert property ($rose(cfg_valid) |=> pin_oe == 12'hfff)
    else $error("pins not driven after capture");
  addr_high_a: assert property (cfg.mgmt_addr[4:3] == 2'h0)
    else $error("upper address bits not zero");
  addr_low_a: assert property ($rose(cfg_valid) |-> cfg.mgmt_addr[2:0] == mgmt_addr_strap_bit_i)
    else $error("low address differs from straps");
  bcast_a: assert property ($rose(cfg_valid) |-> cfg.bcast_en == !broadcast_addr_disable_strap)
    else $error("broadcast handling wrong");
  mode_map_a: assert property ($rose(cfg_valid) |->
    cfg.mode == (mode_strap_i == 3'h0 ? scl_pkg::SCL_MODE_MII :
    mode_strap_i == 3'h6 ? scl_pkg::SCL_MODE_B2B : scl_pkg::SCL_MODE_RSVD))
    else $error("mode code mapped wrong");
  test_mode_a: assert property ($rose(cfg_valid) |-> cfg.test_mode_en == !conn_test_strap_n_i)
    else $error("test mode wrong");
  ctrl_seed_a: assert property ($rose(cfg_valid) |->
    ctrl_reg == {2'h0, speed_strap_i, autoneg_enable_strap, 1'b0, isolate_strap_i, 1'b0, duplex_strap_i, 8'h00})
    else $error("control seed wrong");
  adv_seed_a: assert property ($rose(cfg_valid) |->
    adv_reg == {7'h00, speed_strap_i, speed_strap_i, 2'h3, 4'h0, 1'b1})
    else $error("advertisement seed wrong");
  cfg_hold_a: assert property (cfg_valid |=> $stable(cfg))
    else $error("latched config changed");
endmodule
bind scl_top scl_top_assertions chk (.ref_clk, .resetn, .mgmt_addr_strap_bit_i, .mode_strap_i, .isolate_strap_i,
  .speed_strap_i, .duplex_strap_i, .autoneg_enable_strap, .broadcast_addr_disable_strap, .conn_test_strap_n_i,
  .pin_oe, .cfg_valid, .cfg, .ctrl_reg, .adv_reg);
`default_nettype wire

// file: verification/strap_config_latch_test.sv
// self-checking bench for the strap config latch
`timescale 1ns/10ps
`default_nettype none
module strap_config_latch_test;
  logic ref_clk, resetn;
  scl_pkg::scl_axi_req_t req;
  scl_pkg::scl_axi_rsp_t rsp;
  logic [11:0] pull, pin, func, pin_o, pin_oe, s;
  logic cfg_valid;
  scl_pkg::scl_cfg_t cfg;
  logic [15:0] ctrl_reg, adv_reg, lfsr, r16;
  logic [31:0] d, w;
  logic [1:0] r;
  int mismatches, n_tests;
  scl_board board (.pull(pull), .pin_o(pin_o), .pin_oe(pin_oe), .pin(pin));
  scl_top dut (.ref_clk(ref_clk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp), .mgmt_addr_strap_bit_i(pin[2:0]),
    .mode_strap_i(pin[5:3]), .isolate_strap_i(pin[6]), .speed_strap_i(pin[7]), .duplex_strap_i(pin[8]),
    .autoneg_enable_strap(pin[9]), .broadcast_addr_disable_strap(pin[10]), .conn_test_strap_n_i(pin[11]),
    .pin_func_out(func), .pin_o(pin_o), .pin_oe(pin_oe), .cfg_valid(cfg_valid), .cfg(cfg), .ctrl_reg(ctrl_reg),
    .adv_reg(adv_reg));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic scl_pkg::scl_cfg_t exp_cfg(input logic [11:0] v);
    scl_pkg::scl_cfg_t c;
    c.mgmt_addr = {2'h0, v[2:0]};
    c.bcast_en = !v[10];
    c.mode = v[5:3] == 3'h0 ? scl_pkg::SCL_MODE_MII : v[5:3] == 3'h6 ? scl_pkg::SCL_MODE_B2B : scl_pkg::SCL_MODE_RSVD;
    c.test_mode_en = !v[11];
    return c;
  endfunction
  function automatic logic [15:0] exp_ctrl(input logic [11:0] v);
    return {2'h0, v[7], v[9], 1'b0, v[6], 1'b0, v[8], 8'h00};
  endfunction
  function automatic logic [15:0] exp_adv(input logic [11:0] v);
    return {7'h00, v[7], v[7], 2'h3, 4'h0, 1'b1};
  endfunction
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    $display("unexpected at %0t: no answer", $time);
    complete_run();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    resp = 2'h3;
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge ref_clk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) give_up();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    v = 32'h0000_0000;
    resp = 2'h3;
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    while (!done && n < 50) begin
      @(posedge ref_clk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        v = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) give_up();
  endtask
  // straps change while reset is low, then stay put past the capture edge
  task automatic do_reset(input logic [11:0] v);
    pull <= v;
    func <= v ^ r16[15:4];
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic check_run(input logic [11:0] v);
    check(cfg_valid, 1'b1);
    check(cfg, exp_cfg(v));
    check(ctrl_reg, exp_ctrl(v));
    check(adv_reg, exp_adv(v));
    check(pin_oe, 12'hfff);
    check(pin_o, func);
    axi_rd(scl_pkg::ADDR_STRAP, d, r);
    check(d, v);
    axi_rd(scl_pkg::ADDR_STATUS, d, r);
    check(d, {22'h00_0000, 1'b1, exp_cfg(v)});
    // board changes after capture must not reach the latched values
    pull <= ~v;
    w = {rnd(), rnd()};
    axi_wr(scl_pkg::ADDR_CTRL, w, r);
    check(r, scl_pkg::RESP_OKAY);
    axi_rd(scl_pkg::ADDR_CTRL, d, r);
    check(d, {16'h0000, w[15:0]});
    check(cfg, exp_cfg(v));
    axi_wr(scl_pkg::ADDR_ADV, ~w, r);
    check(r, scl_pkg::RESP_OKAY);
    axi_rd(scl_pkg::ADDR_ADV, d, r);
    check(d, {16'h0000, ~w[15:0]});
    axi_rd(scl_pkg::ADDR_PIN_OUT, d, r);
    check(d, 32'h0000_0fff);
    axi_wr(scl_pkg::ADDR_STRAP, w, r);
    check(r, scl_pkg::RESP_SLVERR);
    axi_rd(scl_pkg::ADDR_STRAP, d, r);
    check(d, v);
    axi_rd(8'h20, d, r);
    check({d[29:0], r}, {30'h0000_0000, scl_pkg::RESP_SLVERR});
  endtask
  initial begin
    req = '0;
    resetn = 1'b0;
    lfsr = 16'h13e0;
    r16 = 16'h0000;
    pull = scl_pkg::STRAP_DEFAULT;
    func = 12'h000;
    do_reset(scl_pkg::STRAP_DEFAULT);
    check(cfg.mgmt_addr, 5'h01);
    check_run(scl_pkg::STRAP_DEFAULT);
    for (int m = 0; m < 8; m++) begin
      r16 = rnd();
      s = r16[11:0];
      s[5:3] = m[2:0];
      // address 0 with broadcast both kept and disabled
      if (m < 2) s[2:0] = 3'h0;
      if (m < 2) s[10] = m[0];
      if (m == 7) s[2:0] = 3'h7;
      do_reset(s);
      check_run(s);
    end
    complete_run();
  end
endmodule
`default_nettype wire
